// >>> ipw_core.sv
/*
  Indexed port watchdog core: index/data port pair with unlock key,
  logical device select, enable, arm, time base and timeout count,
  and the down counter that raises a system reset pulse.
  Assumes i/o write and read strobes are one-cycle pulses on the
  core clock, from logic in the same clock domain.
*/
// How it works
// RQ1 - count down, pulse system reset at zero
// RQ2 - host loads count, restarts it periodically
// RQ3 - low port takes index, next port data
// RQ4 - two key writes in a row unlock
// RQ5 - device number at index 07 selects bank
// RQ6 - enable bit turns logical device on
// RQ7 - activate value arms the counter
// RQ8 - timeout register holds eight bit count
// RQ9 - zero disables, else count of units
// RQ10 - time base code picks seconds or minutes
// RQ11 - host timeout exceeds its restart interval
// RQ12 - timeout write reloads and restarts unit
`timescale 1ns/1ps
`include "ipw_consts.svh"

module ipw_core
  import ipw_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `IPW_SEC_CYC
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // host i/o cycles
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  output logic [7:0]       o_io_rdata,
  // system reset request
  output logic             o_sys_reset
);

  ipw_core_state_type s_reg;
  ipw_core_state_type s_next;
  logic               wr_idx;
  logic               wr_dat;
  logic               cfg_open;
  logic               wr_timeout;
  logic               armed;
  logic               sec_tick;
  logic               unit_tick;
  logic               fire;

  // bank registers answer only while the watchdog device is selected
  function automatic logic bank_hit(input logic [7:0] ldn);
    bank_hit = (ldn == `IPW_LDN_WATCHDOG);
  endfunction

  assign wr_idx = i_io_wr && (i_io_addr == `IPW_INDEX_PORT); // RQ3
  assign wr_dat = i_io_wr && (i_io_addr == `IPW_DATA_PORT); // RQ3
  assign cfg_open = (s_reg.unlock == IPW_OPEN);
  assign wr_timeout = cfg_open && wr_dat && bank_hit(s_reg.ldn)
                      && (s_reg.index == `IPW_IDX_TIMEOUT); // RQ8
  assign armed = s_reg.enable[`IPW_ENABLE_BIT] // RQ6
                 && s_reg.activate[`IPW_ARM_BIT]; // RQ7
  // minute mode ticks on the last second of each minute
  assign unit_tick = s_reg.tbase[`IPW_TBASE_MIN_BIT] ? // RQ10
                     (sec_tick && s_reg.min_cnt == `IPW_MIN_LAST_SEC) :
                     sec_tick;
  assign fire = !wr_timeout && armed && unit_tick
                && (s_reg.cnt == 8'h01); // RQ1

  ipw_tick #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_tick (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_restart  (wr_timeout),
    .o_tick     (sec_tick)
  );

  always_comb begin
    s_next = s_reg;
    // unlock: any other index or data port write between the keys starts over
    case (s_reg.unlock)
      IPW_LOCKED: begin
        if (wr_idx && i_io_wdata == `IPW_UNLOCK_KEY) begin
          s_next.unlock = IPW_HALF; // RQ4
        end
      end
      IPW_HALF: begin
        if (wr_idx && i_io_wdata == `IPW_UNLOCK_KEY) begin
          s_next.unlock = IPW_OPEN; // RQ4
        end else if (wr_idx || wr_dat) begin
          s_next.unlock = IPW_LOCKED;
        end
      end
      IPW_OPEN: begin
        s_next.unlock = IPW_OPEN;
      end
      default: begin
        s_next.unlock = IPW_LOCKED;
      end
    endcase

    if (cfg_open && wr_idx) begin
      s_next.index = i_io_wdata; // RQ3
    end
    if (cfg_open && wr_dat) begin
      if (s_reg.index == `IPW_IDX_LDN) begin
        s_next.ldn = i_io_wdata; // RQ5
      end else if (bank_hit(s_reg.ldn)) begin
        case (s_reg.index)
          `IPW_IDX_ENABLE: begin
            s_next.enable = i_io_wdata; // RQ6
          end
          `IPW_IDX_ACTIVATE: begin
            s_next.activate = i_io_wdata; // RQ7
          end
          `IPW_IDX_TBASE: begin
            s_next.tbase = i_io_wdata; // RQ10
          end
          default: begin
            s_next.tbase = s_reg.tbase;
          end
        endcase
      end
    end

    // a reload beats a unit tick in the same cycle
    if (wr_timeout) begin
      s_next.cnt = i_io_wdata; // RQ12
      s_next.min_cnt = 6'h00; // RQ12
    end else begin
      if (sec_tick) begin
        s_next.min_cnt = (s_reg.min_cnt == `IPW_MIN_LAST_SEC) ?
                         6'h00 : s_reg.min_cnt + 6'h01;
      end
      // a zero count never moves and never fires
      if (armed && unit_tick && s_reg.cnt != 8'h00) begin
        s_next.cnt = s_reg.cnt - 8'h01; // RQ9
      end
    end

    if (fire) begin
      s_next.pulse = 5'(`IPW_RST_PULSE_CYC); // RQ1
    end else if (s_reg.pulse != 5'h00) begin
      s_next.pulse = s_reg.pulse - 5'h01;
    end
    s_next.sys_reset = (s_next.pulse != 5'h00);

    // read data stands until the next read cycle
    if (i_io_rd) begin
      s_next.rdata = 8'h00;
      if (cfg_open && i_io_addr == `IPW_INDEX_PORT) begin
        s_next.rdata = s_reg.index;
      end else if (cfg_open && i_io_addr == `IPW_DATA_PORT) begin
        if (s_reg.index == `IPW_IDX_LDN) begin
          s_next.rdata = s_reg.ldn;
        end else if (bank_hit(s_reg.ldn)) begin
          case (s_reg.index)
            `IPW_IDX_ENABLE: begin
              s_next.rdata = s_reg.enable;
            end
            `IPW_IDX_ACTIVATE: begin
              s_next.rdata = s_reg.activate;
            end
            `IPW_IDX_TBASE: begin
              s_next.rdata = s_reg.tbase;
            end
            `IPW_IDX_TIMEOUT: begin
              s_next.rdata = s_reg.cnt; // RQ8
            end
            default: begin
              s_next.rdata = 8'h00;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg.unlock    <= IPW_LOCKED;
      s_reg.index     <= `IPW_RST_BYTE;
      s_reg.ldn       <= `IPW_RST_BYTE;
      s_reg.enable    <= `IPW_RST_BYTE;
      s_reg.activate  <= `IPW_RST_BYTE;
      s_reg.tbase     <= `IPW_RST_TBASE;
      s_reg.cnt       <= `IPW_RST_BYTE;
      s_reg.min_cnt   <= 6'h00;
      s_reg.pulse     <= 5'h00;
      s_reg.sys_reset <= 1'b0;
      s_reg.rdata     <= `IPW_RST_BYTE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_io_rdata = s_reg.rdata;
  assign o_sys_reset = s_reg.sys_reset;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_fire;
    fire |=> o_sys_reset && s_reg.cnt == 8'h00;
  endproperty
  a_fire: assert property (p_fire) // RQ1
    else $error("no system reset on count reaching zero");

  property p_pulse_len;
    $rose(o_sys_reset) |-> o_sys_reset [*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len) // RQ1
    else $error("system reset pulse too short");

  property p_index;
    cfg_open && wr_idx |=> s_reg.index == $past(i_io_wdata);
  endproperty
  a_index: assert property (p_index) // RQ3
    else $error("index port write not stored");

  property p_locked;
    !cfg_open && wr_dat |=> $stable(s_reg.ldn) && $stable(s_reg.cnt);
  endproperty
  a_locked: assert property (p_locked) // RQ4
    else $error("data write took effect while locked");

  property p_unlock;
    s_reg.unlock == IPW_HALF && wr_idx
      && i_io_wdata == `IPW_UNLOCK_KEY |=> cfg_open;
  endproperty
  a_unlock: assert property (p_unlock) // RQ4
    else $error("second key did not open configuration");

  property p_ldn;
    cfg_open && wr_dat && s_reg.index == `IPW_IDX_LDN
      |=> s_reg.ldn == $past(i_io_wdata);
  endproperty
  a_ldn: assert property (p_ldn) // RQ5
    else $error("logical device select not stored");

  property p_disabled;
    !s_reg.enable[`IPW_ENABLE_BIT] && !wr_timeout
      |=> s_reg.cnt == $past(s_reg.cnt);
  endproperty
  a_disabled: assert property (p_disabled) // RQ6
    else $error("counter moved while device disabled");

  property p_decrement;
    armed && unit_tick && s_reg.cnt > 8'h01 && !wr_timeout
      |=> s_reg.cnt == $past(s_reg.cnt) - 8'h01;
  endproperty
  a_decrement: assert property (p_decrement) // RQ7
    else $error("armed counter did not decrement");

  property p_zero_off;
    s_reg.cnt == 8'h00 && !wr_timeout |=> s_reg.cnt == 8'h00 && !fire;
  endproperty
  a_zero_off: assert property (p_zero_off) // RQ9
    else $error("zero count did not stay disabled");

  // a second that is not the last of its minute leaves the count alone
  property p_minute;
    s_reg.tbase[`IPW_TBASE_MIN_BIT] && sec_tick && !wr_timeout
      && s_reg.min_cnt != `IPW_MIN_LAST_SEC |=> $stable(s_reg.cnt);
  endproperty
  a_minute: assert property (p_minute) // RQ10
    else $error("minute unit ticked early");

  property p_reload;
    wr_timeout |=> s_reg.cnt == $past(i_io_wdata)
                   && s_reg.min_cnt == 6'h00;
  endproperty
  a_reload: assert property (p_reload) // RQ12
    else $error("timeout write did not reload");

  c_open: cover property (s_reg.unlock == IPW_HALF ##1 cfg_open);
  c_fire: cover property (fire ##1 o_sys_reset);
  c_minute: cover property (armed && unit_tick
                            && s_reg.tbase[`IPW_TBASE_MIN_BIT]);

endmodule

// >>> ipw_consts.svh
/*
  Constants of the indexed port watchdog: port addresses, register
  indexes, field positions, reset values and timing counts.
  Assumes a 100 MHz core clock; included by bare name.
*/
`ifndef IPW_CONSTS_SVH
`define IPW_CONSTS_SVH

// host i/o ports and unlock key
`define IPW_INDEX_PORT     16'h002E
`define IPW_DATA_PORT      16'h002F
`define IPW_UNLOCK_KEY     8'h87

// register indexes and watchdog device number
`define IPW_IDX_LDN        8'h07
`define IPW_IDX_ENABLE     8'h30
`define IPW_IDX_ACTIVATE   8'hF0
`define IPW_IDX_TBASE      8'hF5
`define IPW_IDX_TIMEOUT    8'hF6
`define IPW_LDN_WATCHDOG   8'h07

// field positions
`define IPW_ENABLE_BIT     0
`define IPW_ARM_BIT        7
`define IPW_TBASE_MIN_BIT  3

// reset values and time base codes
`define IPW_RST_BYTE       8'h00
`define IPW_RST_TBASE      8'h71
`define IPW_TBASE_SEC      8'h71
`define IPW_TBASE_MIN      8'h79

// timing
`define IPW_CLK_PERIOD_NS  10
`define IPW_SEC_NS         1000000000
`define IPW_SEC_CYC        (`IPW_SEC_NS / `IPW_CLK_PERIOD_NS)
`define IPW_MIN_LAST_SEC   6'h3B
`define IPW_RST_PULSE_NS   160
`define IPW_RST_PULSE_CYC  \
  ((`IPW_RST_PULSE_NS + `IPW_CLK_PERIOD_NS - 1) / `IPW_CLK_PERIOD_NS)

`endif

// >>> ipw_pkg.sv
/*
  Types of the indexed port watchdog: unlock states and the packed
  state records of the core and of the second prescaler.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ipw_pkg;

  typedef enum logic [1:0] {
    IPW_LOCKED = 2'b00,
    IPW_HALF   = 2'b01,
    IPW_OPEN   = 2'b10
  } ipw_unlock_type;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } ipw_tick_state_type;

  typedef struct packed {
    ipw_unlock_type unlock;
    logic [7:0]     index;
    logic [7:0]     ldn;
    logic [7:0]     enable;
    logic [7:0]     activate;
    logic [7:0]     tbase;
    logic [7:0]     cnt;
    logic [5:0]     min_cnt;
    logic [4:0]     pulse;
    logic           sys_reset;
    logic [7:0]     rdata;
  } ipw_core_state_type;

endpackage

// >>> ipw_tick.sv
/*
  Second prescaler: one-cycle tick every SEC_CYCLES core clocks,
  restartable so a reload starts a full unit.
  Assumes i_restart comes from logic on the same clock.
*/
`timescale 1ns/1ps
`include "ipw_consts.svh"

module ipw_tick
  import ipw_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `IPW_SEC_CYC
) (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_restart,
  // one pulse per second
  output logic      o_tick
);

  ipw_tick_state_type s_reg;
  ipw_tick_state_type s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (i_restart) begin
      s_next.cnt = 32'h0000_0000;
    end else if (s_reg.cnt == 32'(SEC_CYCLES - 1)) begin
      s_next.cnt = 32'h0000_0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_tick = s_reg.tick;

endmodule

// >>> ipw_host.sv
/*
  Host software model: i/o port cycles on the index/data pair.
  Assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
`include "ipw_consts.svh"

module ipw_host (
  // clock
  input  wire logic       i_core_clk,
  // i/o cycles to the device
  output logic [15:0]     o_io_addr,
  output logic            o_io_wr,
  output logic            o_io_rd,
  output logic [7:0]      o_io_wdata,
  // read data from the device
  input  wire logic [7:0] i_io_rdata
);
  initial begin
    o_io_addr  = 16'h0000;
    o_io_wr    = 1'b0;
    o_io_rd    = 1'b0;
    o_io_wdata = 8'h00;
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1;
    o_io_addr  = a;
    o_io_wdata = d;
    o_io_wr    = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_io_wr    = 1'b0;
    // released data must not keep looking valid
    o_io_wdata = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    #1;
    o_io_addr = a;
    o_io_rd   = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_io_rd = 1'b0;
    d       = i_io_rdata;
  endtask

  task automatic unlock();
    wr(`IPW_INDEX_PORT, `IPW_UNLOCK_KEY);
    wr(`IPW_INDEX_PORT, `IPW_UNLOCK_KEY);
  endtask

  task automatic set_reg(input logic [7:0] idx, input logic [7:0] d);
    wr(`IPW_INDEX_PORT, idx);
    wr(`IPW_DATA_PORT, d);
  endtask

  task automatic get_reg(input logic [7:0] idx, output logic [7:0] d);
    wr(`IPW_INDEX_PORT, idx);
    rd(`IPW_DATA_PORT, d);
  endtask
endmodule

// >>> ipw_core_bench.sv
/*
  Self-checking bench of the watchdog core with a short second.
  Assumes the host model drives every i/o cycle.
*/
`timescale 1ns/1ps
`include "ipw_consts.svh"

module ipw_core_bench;
  localparam int unsigned SEC = 10;
  localparam int unsigned PW  = `IPW_RST_PULSE_CYC;

  logic        core_clk;
  logic        rst_n;
  logic [15:0] io_addr;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        sys_reset;
  int          err_count;
  int          compares;
  logic [7:0]  rv;

  ipw_core #(.SEC_CYCLES(SEC)) i_dut (
    .i_core_clk  (core_clk),
    .i_rst_n     (rst_n),
    .i_io_addr   (io_addr),
    .i_io_wr     (io_wr),
    .i_io_rd     (io_rd),
    .i_io_wdata  (io_wdata),
    .o_io_rdata  (io_rdata),
    .o_sys_reset (sys_reset)
  );

  ipw_host i_host (
    .i_core_clk (core_clk),
    .o_io_addr  (io_addr),
    .o_io_wr    (io_wr),
    .o_io_rd    (io_rd),
    .o_io_wdata (io_wdata),
    .i_io_rdata (io_rdata)
  );

  always #5 core_clk = ~core_clk;

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  task automatic finish_test();
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask

  task automatic expect_quiet(input int unsigned n);
    int unsigned c;
    c = 0;
    repeat (n) begin
      step();
      if (sys_reset === 1'b0) c++;
    end
    chk("quiet cycles", n, c);
  endtask

  // edges from the reload edge until the request rises, then its width
  task automatic expect_fire(input int unsigned n);
    int unsigned c;
    int unsigned w;
    c = 0;
    w = 0;
    while (sys_reset !== 1'b1 && c < n + 20) begin
      step();
      c++;
    end
    chk("fire delay", n, c);
    if (c >= n + 20) finish_test();
    while (sys_reset === 1'b1 && w < PW + 20) begin
      step();
      w++;
    end
    chk("pulse width", PW, w);
    i_host.get_reg(`IPW_IDX_TIMEOUT, rv);
    chk("count after fire", 8'h00, rv);
  endtask

  task automatic t_locked();
    i_host.set_reg(`IPW_IDX_LDN, `IPW_LDN_WATCHDOG);
    i_host.rd(`IPW_DATA_PORT, rv);
    chk("locked read", 8'h00, rv);
    i_host.wr(`IPW_INDEX_PORT, `IPW_UNLOCK_KEY);
    i_host.wr(`IPW_DATA_PORT, 8'h00);
    i_host.wr(`IPW_INDEX_PORT, `IPW_UNLOCK_KEY);
    i_host.wr(`IPW_INDEX_PORT, `IPW_IDX_LDN);
    i_host.rd(`IPW_INDEX_PORT, rv);
    chk("broken unlock", 8'h00, rv);
    i_host.unlock();
    i_host.wr(`IPW_INDEX_PORT, `IPW_IDX_LDN);
    i_host.rd(`IPW_INDEX_PORT, rv);
    chk("index readback", `IPW_IDX_LDN, rv);
    i_host.rd(`IPW_DATA_PORT, rv);
    chk("ldn kept while locked", 8'h00, rv);
    i_host.rd(16'h0030, rv);
    chk("unmapped read", 8'h00, rv);
  endtask

  task automatic t_regs();
    logic [7:0] ix [3];
    logic [7:0] rs [3];
    logic [7:0] wv [3];
    ix = '{`IPW_IDX_ENABLE, `IPW_IDX_ACTIVATE, `IPW_IDX_TBASE};
    rs = '{`IPW_RST_BYTE, `IPW_RST_BYTE, `IPW_RST_TBASE};
    wv = '{8'h01, 8'h80, `IPW_TBASE_SEC};
    i_host.set_reg(`IPW_IDX_TIMEOUT, 8'h05);
    i_host.set_reg(`IPW_IDX_LDN, `IPW_LDN_WATCHDOG);
    i_host.get_reg(`IPW_IDX_TIMEOUT, rv);
    chk("bank write unselected", 8'h00, rv);
    for (int i = 0; i < 3; i++) begin
      i_host.get_reg(ix[i], rv);
      chk("reset value", rs[i], rv);
      i_host.set_reg(ix[i], wv[i]);
      i_host.get_reg(ix[i], rv);
      chk("readback", wv[i], rv);
    end
  endtask

  task automatic t_fire();
    i_host.set_reg(`IPW_IDX_TIMEOUT, 8'h02);
    expect_fire(2 * SEC + 1);
    i_host.set_reg(`IPW_IDX_TIMEOUT, 8'h02);
    // restart two cycles before the count runs out
    expect_quiet(SEC + 5);
    i_host.set_reg(`IPW_IDX_TIMEOUT, 8'h02);
    expect_fire(2 * SEC + 1);
  endtask

  task automatic t_hold();
    i_host.set_reg(`IPW_IDX_TIMEOUT, 8'h00);
    expect_quiet(3 * SEC);
    i_host.set_reg(`IPW_IDX_ACTIVATE, 8'h00);
    i_host.set_reg(`IPW_IDX_TIMEOUT, 8'hFF);
    expect_quiet(3 * SEC);
    i_host.get_reg(`IPW_IDX_TIMEOUT, rv);
    chk("count frozen", 8'hFF, rv);
    // zero first so arming cannot fire at a stray tick
    i_host.set_reg(`IPW_IDX_TIMEOUT, 8'h00);
    i_host.set_reg(`IPW_IDX_ACTIVATE, 8'h80);
    i_host.set_reg(`IPW_IDX_TBASE, `IPW_TBASE_MIN);
    i_host.set_reg(`IPW_IDX_TIMEOUT, 8'h01);
    expect_fire(60 * SEC + 1);
  endtask

  // a reset in the first cycle of a request pulse drops it and relocks
  task automatic t_reset();
    int unsigned c;
    c = 0;
    i_host.set_reg(`IPW_IDX_TBASE, `IPW_TBASE_SEC);
    i_host.set_reg(`IPW_IDX_TIMEOUT, 8'h01);
    while (sys_reset !== 1'b1 && c < SEC + 20) begin
      step();
      c++;
    end
    chk("fire before reset", SEC + 1, c);
    rst_n = 1'b0;
    #1;
    chk("request in reset", 1'b0, sys_reset);
    repeat (2) step();
    rst_n = 1'b1;
    step();
    chk("request after reset", 1'b0, sys_reset);
    i_host.wr(`IPW_INDEX_PORT, `IPW_IDX_LDN);
    i_host.rd(`IPW_INDEX_PORT, rv);
    chk("relocked", 8'h00, rv);
    i_host.unlock();
    i_host.get_reg(`IPW_IDX_LDN, rv);
    chk("ldn after reset", 8'h00, rv);
    i_host.set_reg(`IPW_IDX_LDN, `IPW_LDN_WATCHDOG);
    i_host.get_reg(`IPW_IDX_TBASE, rv);
    chk("time base after reset", `IPW_RST_TBASE, rv);
    i_host.get_reg(`IPW_IDX_TIMEOUT, rv);
    chk("count after reset", 8'h00, rv);
    i_host.get_reg(8'h31, rv);
    chk("unknown index", 8'h00, rv);
  endtask

  initial begin
    core_clk  = 1'b0;
    rst_n     = 1'b0;
    err_count = 0;
    compares  = 0;
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    chk("idle request", 1'b0, sys_reset);
    t_locked();
    t_regs();
    t_fire();
    t_hold();
    t_reset();
    finish_test();
  end
endmodule
